// ### inc/xpd_pkg.sv
package xpd_pkg;
  // ************************************************
  // special function register addresses
  // ************************************************
  localparam logic [7:0] XPD_AUX1_ADDR = 8'ha2;
  localparam logic [7:0] XPD_AUX_ADDR = 8'h8e;
  localparam logic [7:0] XPD_DPLO_ADDR = 8'h82;
  localparam logic [7:0] XPD_DPHI_ADDR = 8'h83;
  // ************************************************
  // field positions
  // ************************************************
  localparam int XPD_PSEL_BIT = 0;
  localparam int XPD_STUCK_BIT = 2;
  localparam int XPD_UFLAG_BIT = 3;
  localparam int XPD_BOOT_BIT = 5;
  localparam int XPD_EXTSEL_BIT = 1;
  localparam int XPD_XRS_LSB = 2;
  localparam int XPD_STRETCH_BIT = 5;
  // ************************************************
  // reset values
  // ************************************************
  localparam logic XPD_PSEL_RST = 1'b0;
  localparam logic XPD_UFLAG_RST = 1'b0;
  localparam logic XPD_BOOT_RST = 1'b0;
  localparam logic XPD_EXTSEL_RST = 1'b0;
  localparam logic [1:0] XPD_XRS_RST = 2'b00;
  localparam logic XPD_STRETCH_RST = 1'b0;
  // ************************************************
  // memory map
  // ************************************************
  localparam logic [15:0] XPD_BOOT_BASE = 16'hf800;
  localparam int XPD_EXPANDED_RAM_AW = 10;
  localparam int XPD_IRAM_AW = 8;
  localparam logic [10:0] XPD_EXPANDED_RAM_PAGE = 11'h100;
  // ************************************************
  // bus timing, in core clock periods
  // ************************************************
  localparam logic [4:0] XPD_STRB_SHORT = 5'd6;
  localparam logic [4:0] XPD_STRB_LONG = 5'd30;
  localparam logic [4:0] XPD_ALE_CYC = 5'd2;
  typedef enum logic [1:0] {
    XPD_IDLE = 2'b00,
    XPD_ADDR = 2'b01,
    XPD_STRB = 2'b10,
    XPD_HOLD = 2'b11
  } xpd_bus_e;
endpackage

// ### hw/xpd_ram.sv
`timescale 1ns/1ps
module xpd_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_q;

  if (AW < 1 || AW > 16 || DW < 1) begin : g_chk
    $error("xpd_ram: unsupported size");
  end

  // read-before-write: a same-cycle write shows next access
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_q <= mem_q[addr_i];
  end

  assign rdata_o = rdata_q;
endmodule

// ### hw/xpd_xbus.sv
`timescale 1ns/1ps
module xpd_xbus import xpd_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic wr_i,
  input wire logic wide_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic stretch_i,
  input wire logic [7:0] p0_sync_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic [7:0] p0_o,
  output logic p0_oe_n_o,
  output logic [7:0] p2_o,
  output logic p2_oe_n_o,
  output logic ale_o,
  output logic wr_n_o,
  output logic rd_n_o
);
  xpd_bus_e st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] addr_q;
  logic [7:0] wdata_q, rdata_q;
  logic wr_q, wide_q, done_q;
  logic last;

  assign last = (cnt_q == 5'd0);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      XPD_IDLE: begin
        if (start_i) begin
          st_d = XPD_ADDR;
          cnt_d = XPD_ALE_CYC - 5'd1;
        end
      end
      XPD_ADDR: begin
        cnt_d = cnt_q - 5'd1;
        if (last) begin
          st_d = XPD_STRB;
          // stretch picks length
          // slow peripherals get the long strobe
          cnt_d = (stretch_i ? XPD_STRB_LONG : XPD_STRB_SHORT) - 5'd1;
        end
      end
      XPD_STRB: begin
        cnt_d = cnt_q - 5'd1;
        if (last) begin
          st_d = XPD_HOLD;
        end
      end
      XPD_HOLD: st_d = XPD_IDLE;
      default: st_d = XPD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= XPD_IDLE;
      cnt_q <= 5'd0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      wr_q <= 1'b0;
      wide_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_q <= (st_q == XPD_HOLD);
      if (st_q == XPD_IDLE && start_i) begin
        addr_q <= addr_i;
        wdata_q <= wdata_i;
        wr_q <= wr_i;
        wide_q <= wide_i;
      end
      if (st_q == XPD_STRB && last && !wr_q) begin
        rdata_q <= p0_sync_i;
      end
    end
  end

  // low address on p0 first, then data; p0 released while reading
  assign ale_o = (st_q == XPD_ADDR);
  assign p0_o = (st_q == XPD_ADDR) ? addr_q[7:0] : wdata_q;
  assign p0_oe_n_o = !((st_q == XPD_ADDR) ||
                       (wr_q && (st_q == XPD_STRB || st_q == XPD_HOLD)));
  assign p2_o = addr_q[15:8];
  assign p2_oe_n_o = !(wide_q && st_q != XPD_IDLE);
  assign wr_n_o = !(st_q == XPD_STRB && wr_q);
  assign rd_n_o = !(st_q == XPD_STRB && !wr_q);
  assign busy_o = (st_q != XPD_IDLE);
  assign done_o = done_q;
  assign rdata_o = rdata_q;
endmodule

// ### hw/xpd_xdata_decode.sv
// Functional notes
// - two independent 16-bit data pointers; only the selected one is used
// - pointer select bit 0: clear picks pointer 0, set picks pointer 1
// - bit 2 reads zero, ignores writes; increment toggles only the select
// - bit 3 is a plain read/write user flag without hardware effect
// - bit 5 set maps boot ROM at code f800 to ffff; clear disables it
// - reset clears pointer select; stuck bit reads zero
// - expanded RAM sits at the bottom of external data space, to 3ff
// - internal data-move hits expanded RAM; ports and strobes stay idle
// - data-move above enabled size runs a normal external bus cycle
// - register-indirect moves use 8-bit address; above ff needs pointer
// - external select set: register-indirect move puts 8-bit address on p0
// - pointer move: p2 holds high byte, p0 multiplexes low byte and data
// - external moves pulse write strobe for writes, read strobe for reads
// - internal RAM 00 to 7f reachable directly and indirectly
// - direct 80 to ff hits registers; indirect hits separate upper RAM
// - stack only reaches the 256-byte internal RAM
// - stretch bit set makes strobes 30 clocks instead of 6
// - size bits pick 256, 512, 768 or 1024 bytes; 256 at reset
// - external select loaded from security byte after power-up
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module xpd_xdata_decode import xpd_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_ind_i,
  input wire logic reg_stack_i,
  output logic [7:0] reg_rdata_o,
  input wire logic dp_load_i,
  input wire logic [15:0] dp_load_val_i,
  input wire logic dp_inc_i,
  output logic [15:0] dp_sel_o,
  input wire logic mx_rd_i,
  input wire logic mx_wr_i,
  input wire logic mx_use_dp_i,
  input wire logic [7:0] mx_ri_i,
  input wire logic [7:0] mx_wdata_i,
  output logic mx_busy_o,
  output logic mx_done_o,
  output logic [7:0] mx_rdata_o,
  input wire logic [15:0] code_addr_i,
  output logic boot_hit_o,
  input wire logic hsb_ext_sel_i,
  input wire logic [7:0] p0_i,
  output logic [7:0] p0_o,
  output logic p0_oe_n_o,
  output logic [7:0] p2_o,
  output logic p2_oe_n_o,
  output logic ale_o,
  output logic wr_n_o,
  output logic rd_n_o
);
  // ************************************************
  // declarations
  // ************************************************
  logic [7:0] p0_s1_q, p0_s2_q;
  logic hsb_s1_q, hsb_s2_q;
  logic [1:0] init_q;
  logic ptr_sel_q, uflag_q, boot_en_q;
  logic ext_sel_q, stretch_q;
  logic [1:0] xrs_q;
  logic [15:0] dp0_q, dp1_q;
  logic [7:0] sfr_q;
  logic rd_sfr_q, expanded_ram_done_q, src_bus_q;
  logic [7:0] iram_q, expanded_ram_q, bus_rdata;
  logic bus_busy, bus_done;

  // ************************************************
  // decode
  // ************************************************
  wire hsb_load = (init_q == 2'd2);
  // stack and indirect accesses never reach register space
  wire sfr_hit = !reg_ind_i && !reg_stack_i && reg_addr_i[7];
  wire iram_we = reg_wr_i && !sfr_hit;
  wire hit_aux1 = sfr_hit && (reg_addr_i == XPD_AUX1_ADDR);
  wire hit_aux = sfr_hit && (reg_addr_i == XPD_AUX_ADDR);
  wire hit_dplo = sfr_hit && (reg_addr_i == XPD_DPLO_ADDR);
  wire hit_dphi = sfr_hit && (reg_addr_i == XPD_DPHI_ADDR);
  wire wr_aux1 = reg_wr_i && hit_aux1;
  wire wr_aux = reg_wr_i && hit_aux;
  wire wr_dplo = reg_wr_i && hit_dplo;
  wire wr_dphi = reg_wr_i && hit_dphi;

  wire [15:0] dp_sel = ptr_sel_q ? dp1_q : dp0_q;
  wire [7:0] dp_sel_hi = dp_sel[15:8];

  wire [7:0] aux1_rd = {2'b00, boot_en_q, 1'b0, uflag_q,
                        1'b0, 1'b0, ptr_sel_q};
  wire [7:0] aux_rd = {2'b00, stretch_q, 1'b0, xrs_q,
                       ext_sel_q, 1'b0};
  wire [7:0] sfr_rd = hit_aux1 ? aux1_rd :
                      hit_aux ? aux_rd :
                      hit_dplo ? dp_sel[7:0] :
                      hit_dphi ? dp_sel_hi : 8'h00;

  wire mx_req = (mx_rd_i || mx_wr_i) && !bus_busy;
  wire [15:0] mx_addr = mx_use_dp_i ? dp_sel : {8'h00, mx_ri_i};
  wire [10:0] expanded_ram_lim = {1'b0, xrs_q, 8'h00} + XPD_EXPANDED_RAM_PAGE;
  wire in_expanded_ram = !ext_sel_q && (mx_addr < {5'b00000, expanded_ram_lim});
  wire expanded_ram_go = mx_req && in_expanded_ram;
  wire bus_go = mx_req && !in_expanded_ram;

  // ************************************************
  // pointer update
  // ************************************************
  function automatic logic [15:0] dp_upd(input logic [15:0] cur,
                                         input logic mine);
    logic [15:0] nxt;
    nxt = cur;
    if (mine) begin
      if (dp_load_i) begin
        nxt = dp_load_val_i;
      end else if (dp_inc_i) begin
        nxt = cur + 16'h0001;
      end else if (wr_dplo) begin
        nxt = {cur[15:8], reg_wdata_i};
      end else if (wr_dphi) begin
        nxt = {reg_wdata_i, cur[7:0]};
      end
    end
    return nxt;
  endfunction

  // ************************************************
  // pin synchronisers and strap capture
  // ************************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
      hsb_s1_q <= 1'b0;
      hsb_s2_q <= 1'b0;
      init_q <= 2'd0;
    end else begin
      p0_s1_q <= p0_i;
      p0_s2_q <= p0_s1_q;
      hsb_s1_q <= hsb_ext_sel_i;
      hsb_s2_q <= hsb_s1_q;
      if (init_q != 2'd3) begin
        init_q <= init_q + 2'd1;
      end
    end
  end

  // ************************************************
  // control registers
  // ************************************************
  // select cleared at reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_sel_q <= XPD_PSEL_RST;
      uflag_q <= XPD_UFLAG_RST;
      boot_en_q <= XPD_BOOT_RST;
    end else if (wr_aux1) begin
      ptr_sel_q <= reg_wdata_i[XPD_PSEL_BIT];
      uflag_q <= reg_wdata_i[XPD_UFLAG_BIT];
      boot_en_q <= reg_wdata_i[XPD_BOOT_BIT];
    end
  end

  // size bits reset to 256 bytes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_sel_q <= XPD_EXTSEL_RST;
      xrs_q <= XPD_XRS_RST;
      stretch_q <= XPD_STRETCH_RST;
    end else if (wr_aux) begin
      ext_sel_q <= reg_wdata_i[XPD_EXTSEL_BIT];
      xrs_q <= reg_wdata_i[XPD_XRS_LSB +: 2];
      stretch_q <= reg_wdata_i[XPD_STRETCH_BIT];
    end else if (hsb_load) begin
      ext_sel_q <= hsb_s2_q;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dp0_q <= 16'h0000;
      dp1_q <= 16'h0000;
    end else begin
      dp0_q <= dp_upd(dp0_q, !ptr_sel_q);
      dp1_q <= dp_upd(dp1_q, ptr_sel_q);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sfr_q <= 8'h00;
      rd_sfr_q <= 1'b0;
      expanded_ram_done_q <= 1'b0;
      src_bus_q <= 1'b0;
    end else begin
      rd_sfr_q <= reg_rd_i && sfr_hit;
      if (reg_rd_i && sfr_hit) begin
        sfr_q <= sfr_rd;
      end
      expanded_ram_done_q <= expanded_ram_go;
      if (mx_req) begin
        src_bus_q <= bus_go;
      end
    end
  end

  // ************************************************
  // memories
  // ************************************************
  // lower half on every mode
  // stack lands in internal RAM only
  xpd_ram #(.AW(XPD_IRAM_AW), .DW(8)) u_iram (
    .clk_i(clk_i),
    .we_i(iram_we),
    .addr_i(reg_addr_i),
    .wdata_i(reg_wdata_i),
    .rdata_o(iram_q)
  );

  xpd_ram #(.AW(XPD_EXPANDED_RAM_AW), .DW(8)) u_expanded_ram (
    .clk_i(clk_i),
    .we_i(expanded_ram_go && mx_wr_i),
    .addr_i(mx_addr[XPD_EXPANDED_RAM_AW-1:0]),
    .wdata_i(mx_wdata_i),
    .rdata_o(expanded_ram_q)
  );

  // ************************************************
  // external bus
  // ************************************************
  // cycle above enabled size
  xpd_xbus u_xbus (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(bus_go),
    .wr_i(mx_wr_i),
    .wide_i(mx_use_dp_i),
    .addr_i(mx_addr),
    .wdata_i(mx_wdata_i),
    .stretch_i(stretch_q),
    .p0_sync_i(p0_s2_q),
    .busy_o(bus_busy),
    .done_o(bus_done),
    .rdata_o(bus_rdata),
    .p0_o(p0_o),
    .p0_oe_n_o(p0_oe_n_o),
    .p2_o(p2_o),
    .p2_oe_n_o(p2_oe_n_o),
    .ale_o(ale_o),
    .wr_n_o(wr_n_o),
    .rd_n_o(rd_n_o)
  );

  // ************************************************
  // outputs
  // ************************************************
  // both sources are registers, so the mux is glitch free
  assign reg_rdata_o = rd_sfr_q ? sfr_q : iram_q;
  assign mx_rdata_o = src_bus_q ? bus_rdata : expanded_ram_q;
  assign mx_done_o = expanded_ram_done_q || bus_done;
  assign mx_busy_o = bus_busy;
  assign dp_sel_o = dp_sel;
  assign boot_hit_o = boot_en_q && (code_addr_i >= XPD_BOOT_BASE);

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic [5:0] lo_cnt_q, exp_len_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lo_cnt_q <= 6'd0;
      exp_len_q <= 6'd0;
    end else begin
      lo_cnt_q <= (!rd_n_o || !wr_n_o) ? lo_cnt_q + 6'd1 : 6'd0;
      if (bus_go) begin
        exp_len_q <= stretch_q ? {1'b0, XPD_STRB_LONG}
                               : {1'b0, XPD_STRB_SHORT};
      end
    end
  end

  a_sel_load: assert property (dp_load_i && !ptr_sel_q |=>
    dp0_q == $past(dp_load_val_i) && dp1_q == $past(dp1_q))
    else $error("load hit the wrong pointer");
  a_aux1_read: assert property (reg_rd_i && hit_aux1 |=>
    reg_rdata_o[XPD_STUCK_BIT] == 1'b0 &&
    reg_rdata_o[XPD_PSEL_BIT] == $past(ptr_sel_q))
    else $error("aux1 read value wrong");
  a_flag_write: assert property (wr_aux1 |=>
    uflag_q == $past(reg_wdata_i[XPD_UFLAG_BIT]) &&
    boot_en_q == $past(reg_wdata_i[XPD_BOOT_BIT]))
    else $error("flag write not stored");
  a_boot_window: assert property (boot_hit_o |->
    boot_en_q && code_addr_i[15:11] == 5'h1f)
    else $error("boot map outside window");
  a_expanded_ram_quiet: assert property (expanded_ram_go |=>
    rd_n_o && wr_n_o && p0_oe_n_o && p2_oe_n_o)
    else $error("pins moved on internal access");
  a_expanded_ram_size: assert property (mx_req && mx_use_dp_i &&
    !ext_sel_q && dp_sel_hi > {6'h00, xrs_q} |-> bus_go)
    else $error("address above size stayed inside");
  a_wr_strobe: assert property (bus_go && mx_wr_i |->
    ##3 (!wr_n_o && rd_n_o))
    else $error("write strobe missing");
  a_ri_narrow: assert property (bus_go && !mx_use_dp_i |->
    ##1 p2_oe_n_o [*3])
    else $error("p2 driven on narrow move");
  a_dp_high: assert property (bus_go && mx_use_dp_i |->
    ##1 (!p2_oe_n_o && p2_o == $past(dp_sel_hi)))
    else $error("p2 lacks pointer high byte");
  a_strobe_len: assert property ($rose(rd_n_o && wr_n_o) |->
    lo_cnt_q == exp_len_q)
    else $error("strobe length wrong");
  a_sfr_apart: assert property (reg_wr_i &&
    (reg_ind_i || reg_stack_i) |=>
    ptr_sel_q == $past(ptr_sel_q) && uflag_q == $past(uflag_q))
    else $error("indirect write reached registers");

  c_bus_read: cover property (bus_go && mx_rd_i ##[1:40] bus_done);
  c_expanded_ram_write: cover property (expanded_ram_go && mx_wr_i);
  c_ptr_toggle: cover property (wr_aux1 ##[1:4] dp_inc_i);
  c_long_strobe: cover property ($rose(rd_n_o) && lo_cnt_q == 6'd30);
endmodule

// ### verif/xpd_xmem_model.sv
`timescale 1ns/1ps
module xpd_xmem_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [7:0] p0_i,
  input wire logic p0_oe_n_i,
  input wire logic [7:0] p2_i,
  input wire logic p2_oe_n_i,
  input wire logic ale_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  output logic [7:0] p0_bus_o
);
  logic [7:0] mem [0:65535];
  logic [15:0] adr_q;
  logic [7:0] idle_q;
  logic [1:0] lag_q;
  logic drv;
  // ************************************************
  // pin resolution
  // ************************************************
  // data only while read strobe low
  assign drv = !rd_n_i && p0_oe_n_i && (!slow_i || lag_q == 2'd2);
  // released bus never holds a stale value
  assign p0_bus_o = !p0_oe_n_i ? p0_i : drv ? mem[adr_q] : idle_q;
  always @(posedge clk_i) begin
    idle_q <= ~p0_bus_o;
    // latch; undriven p2 reads as page 0
    if (ale_i) begin
      adr_q <= {p2_oe_n_i ? 8'h00 : p2_i, p0_i};
    end
    lag_q <= rd_n_i ? 2'd0 : (lag_q == 2'd2 ? lag_q : lag_q + 2'd1);
    // write data taken while strobe low
    if (!wr_n_i) begin
      mem[adr_q] <= p0_bus_o;
    end
  end
endmodule

// ### verif/test_xpd_xdata_decode.sv
`timescale 1ns/1ps
module test_xpd_xdata_decode import xpd_pkg::*;;
  logic clk_i, reset_i, reg_wr_i, reg_rd_i, reg_ind_i, reg_stack_i;
  logic dp_load_i, dp_inc_i, mx_rd_i, mx_wr_i, mx_use_dp_i;
  logic hsb_ext_sel_i, slow, mx_busy_o, mx_done_o, boot_hit_o;
  logic p0_oe_n_o, p2_oe_n_o, ale_o, wr_n_o, rd_n_o;
  logic [7:0] reg_addr_i, reg_wdata_i, mx_ri_i, mx_wdata_i;
  logic [7:0] reg_rdata_o, mx_rdata_o, p0_o, p2_o, p0_bus, d, r, m, p2v;
  logic [15:0] dp_load_val_i, dp_sel_o, code_addr_i, a, b, rs;
  int failures, comparisons, cyc, n, lw, lr, tch, p2d;
  xpd_xdata_decode xpd_xdata_decode_inst (.clk_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_ind_i, .reg_stack_i,
    .reg_rdata_o, .dp_load_i, .dp_load_val_i, .dp_inc_i, .dp_sel_o,
    .mx_rd_i, .mx_wr_i, .mx_use_dp_i, .mx_ri_i, .mx_wdata_i, .mx_busy_o,
    .mx_done_o, .mx_rdata_o, .code_addr_i, .boot_hit_o, .hsb_ext_sel_i,
    .p0_i(p0_bus), .p0_o, .p0_oe_n_o, .p2_o, .p2_oe_n_o, .ale_o, .wr_n_o,
    .rd_n_o);
  xpd_xmem_model xpd_xmem_model_inst (.clk_i, .slow_i(slow), .p0_i(p0_o),
    .p0_oe_n_i(p0_oe_n_o), .p2_i(p2_o), .p2_oe_n_i(p2_oe_n_o),
    .ale_i(ale_o), .wr_n_i(wr_n_o), .rd_n_i(rd_n_o), .p0_bus_o(p0_bus));
  // ************************************************
  // helpers
  // ************************************************
  function automatic [15:0] nx(input [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic [15:0] lim(input [1:0] s);
    return {6'h00, s, 8'h00} + 16'h0100;
  endfunction
  function automatic [15:0] lat(input e, input st);
    return e ? (st ? 16'd34 : 16'd10) : 16'd1;
  endfunction
  task chk(input string s, input [15:0] e, input [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task rst;
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task rg(input w, input [7:0] ad, input [7:0] wd, input ind, input stk);
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= ad;
    reg_wdata_i <= wd;
    reg_ind_i <= ind;
    reg_stack_i <= stk;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task dp(input ld, input [15:0] v);
    @(posedge clk_i);
    dp_load_i <= ld;
    dp_inc_i <= !ld;
    dp_load_val_i <= v;
    @(posedge clk_i);
    dp_load_i <= 1'b0;
    dp_inc_i <= 1'b0;
    #1;
  endtask
  task bt(input [15:0] ca, input e);
    @(posedge clk_i);
    code_addr_i <= ca;
    #1 chk("boot", {15'h0, e}, {15'h0, boot_hit_o});
  endtask
  // counts strobe cycles and pin activity until done
  task mv(input w, input u, input [7:0] ri, input [7:0] wd);
    @(posedge clk_i);
    mx_wr_i <= w;
    mx_rd_i <= !w;
    mx_use_dp_i <= u;
    mx_ri_i <= ri;
    mx_wdata_i <= wd;
    {lw, lr, tch, p2d} = '0;
    @(posedge clk_i);
    mx_wr_i <= 1'b0;
    mx_rd_i <= 1'b0;
    for (n = 1; n < 40; n++) begin
      #1;
      lw += int'(!wr_n_o);
      lr += int'(!rd_n_o);
      tch += int'(ale_o || !p0_oe_n_o);
      if (!p2_oe_n_o) begin
        p2d++;
        p2v = p2_o;
      end
      if (mx_done_o === 1'b1) break;
      @(posedge clk_i);
    end
    r = mx_rdata_o;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      finish_test;
    end
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    reset_i = 1'b1;
    {reg_wr_i, reg_rd_i, reg_ind_i, reg_stack_i, dp_load_i, dp_inc_i} = '0;
    {mx_rd_i, mx_wr_i, mx_use_dp_i, hsb_ext_sel_i, slow} = '0;
    {reg_addr_i, reg_wdata_i, mx_ri_i, mx_wdata_i} = '0;
    {dp_load_val_i, code_addr_i} = '0;
    rs = 16'h005f;
    rst;
    rg(0, XPD_AUX1_ADDR, 8'h00, 0, 0); chk("aux1", 8'h00, d);
    rg(0, XPD_AUX_ADDR, 8'h00, 0, 0); chk("aux", 8'h00, d);
    rg(0, 8'hf1, 8'h00, 0, 0); chk("unmapped", 8'h00, d);
    rg(1, XPD_AUX1_ADDR, 8'h2d, 0, 0);
    rg(0, XPD_AUX1_ADDR, 8'h00, 0, 0); chk("aux1", 8'h29, d);
    bt(16'hf7ff, 1'b0);
    bt(16'hf800, 1'b1);
    bt(16'hffff, 1'b1);
    rg(1, XPD_AUX1_ADDR, 8'h08, 0, 0);
    bt(16'hf800, 1'b0);
    m = 8'h08;
    repeat (2) begin
      rg(1, XPD_AUX1_ADDR, m + 8'h01, 0, 0);
      m = (m + 8'h01) & 8'h29;
      rg(0, XPD_AUX1_ADDR, 8'h00, 0, 0); chk("aux1 inc", m, d);
    end
    $display("test aux1 done");
    rs = nx(rs);
    a = rs;
    dp(1, a);
    rg(1, XPD_AUX1_ADDR, 8'h09, 0, 0);
    rs = nx(rs);
    dp(1, rs);
    chk("ptr1", rs, dp_sel_o);
    rg(1, XPD_AUX1_ADDR, 8'h08, 0, 0); chk("ptr0", a, dp_sel_o);
    dp(0, 16'h0000);
    a = a + 16'h0001;
    chk("ptr inc", a, dp_sel_o);
    rg(0, XPD_DPLO_ADDR, 8'h00, 0, 0); chk("ptr lo", a[7:0], d);
    rg(0, XPD_DPHI_ADDR, 8'h00, 0, 0); chk("ptr hi", a[15:8], d);
    rg(1, XPD_DPHI_ADDR, rs[15:8], 0, 0);
    a[15:8] = rs[15:8];
    chk("ptr wr", a, dp_sel_o);
    $display("test pointers done");
    for (int s = 0; s < 4; s++) begin
      rg(1, XPD_AUX_ADDR, {4'h0, 2'(s), 2'b00}, 0, 0);
      b = lim(2'(s));
      for (int e = 0; e < 2; e++) begin
        rs = nx(rs);
        dp(1, b - 16'(1 - e));
        mv(1, 1, 8'h00, rs[7:0]);
        chk("latency", lat(e[0], 0), 16'(n));
        chk("wr strobe", e ? 16'd6 : 16'd0, 16'(lw));
        if (e == 0) chk("quiet", 0, 16'(tch + lr + p2d));
        else chk("p2", b[15:8], p2v);
        mv(0, 1, 8'h00, 8'h00);
        chk("rd strobe", e ? 16'd6 : 16'd0, 16'(lr));
        chk("data", rs[7:0], r);
      end
    end
    $display("test sizes done");
    rg(1, XPD_AUX_ADDR, 8'h00, 0, 0);
    mv(1, 0, 8'ha0, rs[15:8]); chk("ri lat", 16'd1, 16'(n));
    dp(1, 16'h00a0);
    mv(0, 1, 8'h00, 8'h00); chk("ri data", rs[15:8], r);
    rg(1, XPD_AUX_ADDR, 8'h02, 0, 0);
    mv(1, 0, 8'h55, rs[7:0]); chk("ri ext", 16'd10, 16'(n));
    chk("ri p2", 16'd0, 16'(p2d));
    mv(0, 0, 8'h55, 8'h00); chk("ri ext data", rs[7:0], r);
    // slow far side on stretched strobes
    rg(1, XPD_AUX_ADDR, 8'h22, 0, 0);
    slow = 1'b1;
    dp(1, a);
    mv(1, 1, 8'h00, rs[15:8]); chk("long lat", lat(1, 1), 16'(n));
    chk("long wr", 16'd30, 16'(lw));
    mv(0, 1, 8'h00, 8'h00); chk("long rd", 16'd30, 16'(lr));
    chk("long data", rs[15:8], r);
    slow = 1'b0;
    $display("test moves done");
    rs = nx(rs);
    rg(1, 8'h30, rs[7:0], 0, 0);
    rg(0, 8'h30, 8'h00, 1, 0); chk("lower", rs[7:0], d);
    rg(1, XPD_AUX1_ADDR, rs[15:8], 1, 0);
    rg(0, XPD_AUX1_ADDR, 8'h00, 0, 0); chk("sfr", m, d);
    rg(0, XPD_AUX1_ADDR, 8'h00, 1, 0); chk("upper", rs[15:8], d);
    rg(0, XPD_AUX1_ADDR, 8'h00, 0, 1); chk("stack", rs[15:8], d);
    $display("test iram done");
    hsb_ext_sel_i <= 1'b1;
    rst;
    rg(0, XPD_AUX_ADDR, 8'h00, 0, 0); chk("strap", 8'h02, d);
    chk("ptr rst", 16'h0000, dp_sel_o);
    $display("test strap done");
    finish_test;
  end
endmodule
